// ### inc/pcrb_cfg.svh
// Register offsets, field positions, reset values and reserved-bit masks
// of the power-management control register bank.
// Assumes inclusion by bare name from the design files.
`ifndef PCRB_CFG_SVH
`define PCRB_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define PCRB_ADDR_REVISION      8'h00
`define PCRB_ADDR_OTP_VER       8'h01
`define PCRB_ADDR_BUCK_CTRL     8'h02
`define PCRB_ADDR_PG_CFG        8'h15
`define PCRB_ADDR_PG_CFG_EXT    8'h16
`define PCRB_ADDR_PWR_FLT       8'h17
`define PCRB_ADDR_SOFT_RST      8'h18
`define PCRB_ADDR_INT_TOP       8'h19
`define PCRB_ADDR_INT_TOP_EXT   8'h1a
`define PCRB_ADDR_BUCK_INT      8'h1b
`define PCRB_ADDR_INT_LIN       8'h1c
`define PCRB_ADDR_STAT_TOP      8'h1d
`define PCRB_ADDR_STAT_BUCK     8'h1e
`define PCRB_ADDR_LIN_STAT      8'h1f
`define PCRB_ADDR_MASK_TOP      8'h20
`define PCRB_ADDR_MASK_TOP_EXT  8'h21
`define PCRB_ADDR_MASK_BUCK     8'h22
`define PCRB_ADDR_MASK_LIN      8'h23
`define PCRB_ADDR_LOAD_SEL      8'h24
`define PCRB_ADDR_LOAD_HIGH     8'h25
`define PCRB_ADDR_LOAD_LOW      8'h26

// ************************************************************
// First buck control fields
// ************************************************************
`define PCRB_BUCK_EN_BIT        0
`define PCRB_BUCK_PIN_GATE_BIT  1
`define PCRB_BUCK_DISCH_BIT     2
`define PCRB_BUCK_FPWM_BIT      3
`define PCRB_BUCK_FPWM_MP_BIT   4
`define PCRB_BUCK_FIELD_MASK    8'h1f
`define PCRB_BUCK_CTRL_RESET    8'h04
`define PCRB_SOFT_RST_BIT       0

// ************************************************************
// Implemented-bit masks of flag and status registers
// ************************************************************
`define PCRB_MASK_INT_TOP       8'hff
`define PCRB_MASK_INT_TOP_EXT   8'h01
`define PCRB_MASK_BUCK_INT      8'h77
`define PCRB_MASK_INT_LIN       8'h77
`define PCRB_MASK_PWR_FLT       8'h0f
`define PCRB_MASK_STAT_TOP      8'h9c
`define PCRB_MASK_STAT_BUCK     8'hdd
`define PCRB_MASK_LIN_STAT      8'hdd
`define PCRB_MASK_LOAD_HIGH     8'h03
`define PCRB_RW_RESET           8'h00

`endif

// ### inc/pcrb_pkg.sv
// Types shared by the register bank and its buck control decoder.
// Assumes the constant header is on the include path.
`default_nettype none

package pcrb_pkg;

    // Serial port receiver states.
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_REG,
        ST_ACK_REG,
        ST_WDATA,
        ST_ACK_WDATA,
        ST_RDATA,
        ST_ACK_MASTER
    } pcrb_state_t;

endpackage

`default_nettype wire

// ### inc/pcrb_buck_if.sv
// Carries the stored first buck control fields from the register bank
// to the buck control decoder; both sit on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface pcrb_buck_if;
    logic [4:0] ctrl;

    modport src (output ctrl);
    modport dst (input  ctrl);
endinterface

`default_nettype wire

// ### rtl/pcrb_buck_ctrl.sv
// Turns the stored first buck control fields and the enable pin into
// registered converter commands.
// Assumes the enable pin is already synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

`include "pcrb_cfg.svh"

module pcrb_buck_ctrl
    import pcrb_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Control fields and pin
    pcrb_buck_if.dst  ctrlBus,
    input  wire logic enPin,
    // Converter commands
    output logic      buckOn,
    output logic      dischargeOn,
    output logic      forcePwm,
    output logic      forceMultiphase
);

    logic onNext;
    logic dischNext;
    logic pwmNext;
    logic mpNext;

    always_comb begin
        onNext    = ctrlBus.ctrl[`PCRB_BUCK_EN_BIT]
                    & (~ctrlBus.ctrl[`PCRB_BUCK_PIN_GATE_BIT] | enPin);
        dischNext = ~onNext & ctrlBus.ctrl[`PCRB_BUCK_DISCH_BIT];
        pwmNext   = ctrlBus.ctrl[`PCRB_BUCK_FPWM_BIT] | ctrlBus.ctrl[`PCRB_BUCK_FPWM_MP_BIT];
        mpNext    = ctrlBus.ctrl[`PCRB_BUCK_FPWM_MP_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            buckOn          <= 1'b0;
            dischargeOn     <= 1'b0;
            forcePwm        <= 1'b0;
            forceMultiphase <= 1'b0;
        end else if (ce) begin
            buckOn          <= onNext;
            dischargeOn     <= dischNext;
            forcePwm        <= pwmNext;
            forceMultiphase <= mpNext;
        end
    end

endmodule // pcrb_buck_ctrl

`default_nettype wire

// ### rtl/pcrb_regbank.sv
// Control and status register bank of a dual buck, dual linear power
// manager, reached over a two-wire serial slave port.
// Assumes scl and sdaIn are synchronous to ref_clk and that the wire's
// level is resolved outside from sdaOut and sdaOe.
//
// Functional notes
// - Revision register returns read-only part code
// - Register one returns read-only OTP version
// - Multiphase bit forces both phases, PWM
// - PWM bit holds converter in PWM
// - Discharge when off only if bit set
// - Pin gating requires enable pin too
// - Bit zero enables the first buck
// - Write index advances per data byte
`timescale 1ns/10ps
`default_nettype none

`include "pcrb_cfg.svh"

module pcrb_regbank
    import pcrb_pkg::*;
#(
    // Device address on the serial port.
    parameter logic [6:0] DEV_ADDR    = 7'h60,
    // Identification values; these defaults are arbitrary.
    parameter logic [1:0] PART_ID     = 2'b00,
    parameter logic [5:0] REV_LOW     = 6'h00,
    parameter logic [7:0] OTP_VERSION = 8'h00
) (
    // Clock and reset
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    // Serial port
    input  wire logic            scl,
    input  wire logic            sdaIn,
    output logic                 sdaOut,
    output logic                 sdaOe,
    // Enable pin
    input  wire logic            enPin,
    // Flag events and status from the analog side
    input  wire logic [3:0][7:0] flagEvent,
    input  wire logic [7:0]      pgFaultIn,
    input  wire logic [7:0]      topStatIn,
    input  wire logic [7:0]      buckStatIn,
    input  wire logic [7:0]      linStatIn,
    input  wire logic [7:0]      loadHighIn,
    input  wire logic [7:0]      loadLowIn,
    // First buck commands
    output logic                 buckOn,
    output logic                 dischargeOn,
    output logic                 forcePwm,
    output logic                 forceMultiphase,
    // Soft reset request
    output logic                 softResetPulse
);

    // ************************************************************
    // Register tables
    // ************************************************************
    localparam int RW_COUNT   = 7;
    localparam int FLAG_COUNT = 4;

    localparam logic [7:0] RW_ADDR [RW_COUNT] = '{
        `PCRB_ADDR_PG_CFG, `PCRB_ADDR_PG_CFG_EXT, `PCRB_ADDR_MASK_TOP,
        `PCRB_ADDR_MASK_TOP_EXT, `PCRB_ADDR_MASK_BUCK, `PCRB_ADDR_MASK_LIN,
        `PCRB_ADDR_LOAD_SEL};

    localparam logic [7:0] FLAG_ADDR [FLAG_COUNT] = '{
        `PCRB_ADDR_INT_TOP, `PCRB_ADDR_INT_TOP_EXT,
        `PCRB_ADDR_BUCK_INT, `PCRB_ADDR_INT_LIN};

    localparam logic [7:0] FLAG_MASK [FLAG_COUNT] = '{
        `PCRB_MASK_INT_TOP, `PCRB_MASK_INT_TOP_EXT,
        `PCRB_MASK_BUCK_INT, `PCRB_MASK_INT_LIN};

    // ************************************************************
    // Declarations
    // ************************************************************
    pcrb_state_t state_q;
    pcrb_state_t state_d;
    logic [3:0]  bitCnt_q;
    logic [3:0]  bitCnt_d;
    logic [7:0]  shift_q;
    logic [7:0]  shift_d;
    logic [7:0]  regIdx_q;
    logic [7:0]  regIdx_d;
    logic [7:0]  rdByte_q;
    logic [7:0]  rdByte_d;
    logic        ackDrive_q;
    logic        ackDrive_d;
    logic        isRead_q;
    logic        isRead_d;
    logic        sdaOe_q;
    logic        sdaOe_d;
    logic        sclPrev_q;
    logic        sdaPrev_q;

    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;
    logic [7:0]  rxByte;
    logic        wrEn;
    logic [7:0]  readMux;

    logic [7:0]  buckCtrl_q;
    logic [7:0]  buckCtrl_d;
    logic        swReset_q;
    logic        swReset_d;
    logic [7:0]  rw_q   [RW_COUNT];
    logic [7:0]  rw_d   [RW_COUNT];
    logic [7:0]  flag_q [FLAG_COUNT];
    logic [7:0]  flag_d [FLAG_COUNT];

    pcrb_buck_if buckBus ();

    // ************************************************************
    // Serial line conditions
    // ************************************************************
    // Pins are already synchronous, so a single previous sample is
    // enough to see edges and start or stop conditions.
    assign sclRise   = scl & ~sclPrev_q;
    assign sclFall   = ~scl & sclPrev_q;
    assign startCond = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopCond  = scl & sclPrev_q & ~sdaPrev_q & sdaIn;
    assign rxByte    = {shift_q[6:0], sdaIn};

    // ************************************************************
    // Serial slave sequencing
    // ************************************************************
    always_comb begin
        state_d    = state_q;
        bitCnt_d   = bitCnt_q;
        shift_d    = shift_q;
        regIdx_d   = regIdx_q;
        rdByte_d   = rdByte_q;
        ackDrive_d = ackDrive_q;
        isRead_d   = isRead_q;
        sdaOe_d    = sdaOe_q;
        wrEn       = 1'b0;
        if (startCond) begin
            state_d    = ST_ADDR;
            bitCnt_d   = 4'h0;
            sdaOe_d    = 1'b0;
            ackDrive_d = 1'b0;
        end else if (stopCond) begin
            state_d    = ST_IDLE;
            sdaOe_d    = 1'b0;
            ackDrive_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: ;
                default: state_d = ST_IDLE;
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (sclRise) begin
                        shift_d  = rxByte;
                        bitCnt_d = bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'h7) begin
                            bitCnt_d = 4'h0;
                            if (state_q == ST_ADDR) begin
                                isRead_d = rxByte[0];
                                state_d  = (rxByte[7:1] == DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE;
                            end else if (state_q == ST_REG) begin
                                regIdx_d = rxByte;
                                state_d  = ST_ACK_REG;
                            end else begin
                                wrEn    = 1'b1;
                                state_d = ST_ACK_WDATA;
                            end
                        end
                    end
                end
                ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WDATA: begin
                    if (sclFall) begin
                        if (!ackDrive_q) begin
                            ackDrive_d = 1'b1;
                            sdaOe_d    = 1'b1;
                        end else begin
                            ackDrive_d = 1'b0;
                            sdaOe_d    = 1'b0;
                            state_d    = ST_WDATA;
                            if (state_q == ST_ACK_WDATA) begin
                                regIdx_d = regIdx_q + 8'h01;
                            end else if (state_q == ST_ACK_ADDR) begin
                                if (isRead_q) begin
                                    rdByte_d = readMux;
                                    sdaOe_d  = ~readMux[7];
                                    state_d  = ST_RDATA;
                                end else begin
                                    state_d = ST_REG;
                                end
                            end
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == 4'h8) begin
                            sdaOe_d  = 1'b0;
                            bitCnt_d = 4'h0;
                            state_d  = ST_ACK_MASTER;
                        end else begin
                            sdaOe_d = ~rdByte_q[3'(4'h7 - bitCnt_q)];
                        end
                    end
                end
                ST_ACK_MASTER: begin
                    if (sclRise) begin
                        if (!sdaIn) begin
                            rdByte_d = readMux;
                            bitCnt_d = 4'h0;
                            state_d  = ST_RDATA;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            bitCnt_q   <= 4'h0;
            shift_q    <= 8'h00;
            regIdx_q   <= 8'h00;
            rdByte_q   <= 8'h00;
            ackDrive_q <= 1'b0;
            isRead_q   <= 1'b0;
            sdaOe_q    <= 1'b0;
            sclPrev_q  <= 1'b1;
            sdaPrev_q  <= 1'b1;
        end else if (ce) begin
            state_q    <= state_d;
            bitCnt_q   <= bitCnt_d;
            shift_q    <= shift_d;
            regIdx_q   <= regIdx_d;
            rdByte_q   <= rdByte_d;
            ackDrive_q <= ackDrive_d;
            isRead_q   <= isRead_d;
            sdaOe_q    <= sdaOe_d;
            sclPrev_q  <= scl;
            sdaPrev_q  <= sdaIn;
        end
    end

    // ************************************************************
    // Read multiplexer
    // ************************************************************
    always_comb begin
        readMux = 8'h00;
        unique case (regIdx_q)
            `PCRB_ADDR_REVISION:  readMux = {PART_ID, REV_LOW};
            `PCRB_ADDR_OTP_VER:   readMux = OTP_VERSION;
            `PCRB_ADDR_BUCK_CTRL: readMux = buckCtrl_q;
            `PCRB_ADDR_PWR_FLT:   readMux = pgFaultIn & `PCRB_MASK_PWR_FLT;
            `PCRB_ADDR_STAT_TOP:  readMux = topStatIn & `PCRB_MASK_STAT_TOP;
            `PCRB_ADDR_STAT_BUCK: readMux = buckStatIn & `PCRB_MASK_STAT_BUCK;
            `PCRB_ADDR_LIN_STAT:  readMux = linStatIn & `PCRB_MASK_LIN_STAT;
            `PCRB_ADDR_LOAD_HIGH: readMux = loadHighIn & `PCRB_MASK_LOAD_HIGH;
            `PCRB_ADDR_LOAD_LOW:  readMux = loadLowIn;
            default:              readMux = 8'h00;
        endcase
        for (int k = 0; k < RW_COUNT; k++) begin
            if (regIdx_q == RW_ADDR[k]) begin
                readMux = rw_q[k];
            end
        end
        for (int k = 0; k < FLAG_COUNT; k++) begin
            if (regIdx_q == FLAG_ADDR[k]) begin
                readMux = flag_q[k];
            end
        end
    end

    // ************************************************************
    // Buck control and soft reset registers
    // ************************************************************
    always_comb begin
        buckCtrl_d = buckCtrl_q;
        swReset_d  = 1'b0;
        if (wrEn && regIdx_q == `PCRB_ADDR_BUCK_CTRL) begin
            buckCtrl_d = rxByte & `PCRB_BUCK_FIELD_MASK;
        end
        // Soft reset reads back as zero; it only issues a one-cycle request.
        if (wrEn && regIdx_q == `PCRB_ADDR_SOFT_RST) begin
            swReset_d = rxByte[`PCRB_SOFT_RST_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            buckCtrl_q <= `PCRB_BUCK_CTRL_RESET;
            swReset_q  <= 1'b0;
        end else if (ce) begin
            buckCtrl_q <= buckCtrl_d;
            swReset_q  <= swReset_d;
        end
    end

    // ************************************************************
    // Plain read-write registers and sticky flags
    // ************************************************************
    for (genvar i = 0; i < RW_COUNT; i++) begin : g_rw
        always_comb begin
            rw_d[i] = (wrEn && regIdx_q == RW_ADDR[i]) ? rxByte : rw_q[i];
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                rw_q[i] <= `PCRB_RW_RESET;
            end else if (ce) begin
                rw_q[i] <= rw_d[i];
            end
        end
    end

    // A new event in the cycle of a clearing write keeps its flag set.
    for (genvar i = 0; i < FLAG_COUNT; i++) begin : g_flag
        always_comb begin
            flag_d[i] = flag_q[i];
            if (wrEn && regIdx_q == FLAG_ADDR[i]) begin
                flag_d[i] = flag_q[i] & ~rxByte;
            end
            flag_d[i] = (flag_d[i] | flagEvent[i]) & FLAG_MASK[i];
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                flag_q[i] <= 8'h00;
            end else if (ce) begin
                flag_q[i] <= flag_d[i];
            end
        end
    end

    // ************************************************************
    // Buck command decoder
    // ************************************************************
    assign buckBus.ctrl = buckCtrl_q[4:0];

    pcrb_buck_ctrl u_buck (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .ctrlBus         (buckBus),
        .enPin           (enPin),
        .buckOn          (buckOn),
        .dischargeOn     (dischargeOn),
        .forcePwm        (forcePwm),
        .forceMultiphase (forceMultiphase)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    // The line is open drain: the driven level is always low.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sdaOut <= 1'b0;
        end else if (ce) begin
            sdaOut <= 1'b0;
        end
    end

    assign sdaOe          = sdaOe_q;
    assign softResetPulse = swReset_q;

endmodule // pcrb_regbank

`default_nettype wire

// ### sim/pcrb_host.sv
// Behavioural two-wire serial host that stands in front of the register bank.
// Assumes an open-drain wire with pull-up resolved by the bench from sdaLow.
`timescale 1ns/10ps
`default_nettype none

module pcrb_host #(
    parameter logic [6:0] DEV_ADDR = 7'h60
) (
    // Clock
    input  wire logic ref_clk,
    // Two-wire bus
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaLow
);
    initial begin
        scl    = 1'b1;
        sdaLow = 1'b0;
    end

    // Three cycles a phase keeps every phase above the two-cycle minimum.
    task automatic half();
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic put(input logic b, output logic r);
        sdaLow = !b;
        half();
        scl = 1'b1;
        half();
        r   = sdaWire;
        scl = 1'b0;
        half();
    endtask

    task automatic start();
        sdaLow = 1'b0;
        half();
        scl = 1'b1;
        half();
        sdaLow = 1'b1;
        half();
        scl = 1'b0;
        half();
    endtask

    task automatic stop();
        sdaLow = 1'b1;
        half();
        scl = 1'b1;
        half();
        sdaLow = 1'b0;
        half();
    endtask

    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put(d[i], r);
        end
        put(1'b1, r);
        ack = !r;
    endtask

    task automatic byteIn(input logic nak, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put(1'b1, d[i]);
        end
        put(nak, r);
    endtask

    task automatic probe(input logic [6:0] adr, output logic ack);
        start();
        byteOut({adr, 1'b0}, ack);
        stop();
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d [$], output logic ok);
        logic a;
        probeless: begin
            start();
            byteOut({DEV_ADDR, 1'b0}, ok);
            byteOut(idx, a);
            ok &= a;
            foreach (d[i]) begin
                byteOut(d[i], a);
                ok &= a;
            end
            stop();
        end
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d0, output logic [7:0] d1,
                      output logic ok);
        logic a;
        start();
        byteOut({DEV_ADDR, 1'b0}, ok);
        byteOut(idx, a);
        ok &= a;
        start();
        byteOut({DEV_ADDR, 1'b1}, a);
        ok &= a;
        byteIn(1'b0, d0);
        byteIn(1'b1, d1);
        stop();
    endtask
endmodule // pcrb_host

`default_nettype wire

// ### sim/pcrb_regbank_sva.sv
// Port-level checker of the register bank, bound from the bench.
// Assumes ce is held high, so every clock edge is a working edge.
`timescale 1ns/10ps
`default_nettype none

module pcrb_regbank_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Serial port and pin
    input wire logic scl,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic enPin,
    // Converter commands
    input wire logic buckOn,
    input wire logic dischargeOn,
    input wire logic forcePwm,
    input wire logic forceMultiphase,
    input wire logic softResetPulse
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [3:0] sinceFall_q, sinceFall_d, quiet_q, quiet_d;
    logic       sclPrev_q, enPrev_q;

    // Ages since the last scl fall and since the last possible command cause.
    always_comb begin
        sinceFall_d = (sclPrev_q && !scl) ? 4'h0 : sinceFall_q + {3'h0, sinceFall_q != 4'hf};
        quiet_d     = ((!sclPrev_q && scl) || enPrev_q != enPin) ? 4'h0 :
                      quiet_q + {3'h0, quiet_q != 4'hf};
    end

    always_ff @(posedge ref_clk) begin
        sinceFall_q <= rst_n ? sinceFall_d : 4'hf;
        quiet_q     <= rst_n ? quiet_d : 4'hf;
        sclPrev_q   <= rst_n ? scl : 1'b1;
        enPrev_q    <= enPin;
    end

    sequence s_pulseGone;
        ##1 !softResetPulse [*3];
    endsequence

    a_disch_when_off: assert property (dischargeOn |-> !buckOn)
        else $error("discharge while converter on");
    a_mp_forces_pwm: assert property (forceMultiphase |-> forcePwm)
        else $error("multiphase forcing without forced PWM");
    a_on_has_cause: assert property ($changed(buckOn) |-> quiet_q <= 4'd4)
        else $error("enable changed without cause");
    a_pwm_has_cause: assert property ($changed(forcePwm) |-> quiet_q <= 4'd4)
        else $error("PWM forcing changed without a write");
    a_mp_has_cause: assert property ($changed(forceMultiphase) |-> quiet_q <= 4'd4)
        else $error("multiphase forcing changed without a write");
    a_oe_after_fall: assert property ($changed(sdaOe) |-> sinceFall_q <= 4'd3)
        else $error("data line drive changed away from a clock fall");
    a_pulse_single: assert property (softResetPulse |-> s_pulseGone)
        else $error("soft reset pulse longer than one cycle");
    a_open_drain: assert property (sdaOut == 1'b0)
        else $error("data line driven high");
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !buckOn && !sdaOe && !forcePwm && !softResetPulse)
        else $error("outputs active during reset");
endmodule // pcrb_regbank_sva

`default_nettype wire

// ### sim/tb.sv
// Self-checking bench of the register bank driven by the serial host model.
// Assumes ce stays high; status inputs share one bench byte.
`timescale 1ns/10ps
`default_nettype none

module tb;
    // Identification values; arbitrary.
    localparam logic [1:0] PART_ID     = 2'b10;
    localparam logic [5:0] REV_LOW     = 6'h15;
    localparam logic [7:0] OTP_VERSION = 8'h5a;

    logic       ref_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic       enPin   = 1'b0;
    logic [7:0] stat    = 8'h00;
    logic       scl, sdaLow, sdaOe, sdaOut, sdaWire, ok;
    logic       buckOn, dischargeOn, forcePwm, forceMultiphase, softResetPulse;
    logic [7:0] d0, d1;
    int         errCount, checkCount, cycles, pulses;

    always #5 ref_clk = ~ref_clk;
    assign sdaWire = !(sdaOe | sdaLow);

    pcrb_host i_pcrb_host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

    pcrb_regbank #(.PART_ID(PART_ID), .REV_LOW(REV_LOW), .OTP_VERSION(OTP_VERSION)) i_pcrb_regbank (
        .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .enPin(enPin), .flagEvent({4{stat}}),
        .pgFaultIn(stat), .topStatIn(stat), .buckStatIn(stat), .linStatIn(stat),
        .loadHighIn(stat), .loadLowIn(stat), .buckOn(buckOn), .dischargeOn(dischargeOn),
        .forcePwm(forcePwm), .forceMultiphase(forceMultiphase),
        .softResetPulse(softResetPulse));

    always @(posedge ref_clk) begin
        cycles++;
        pulses += int'(softResetPulse === 1'b1);
        if (cycles == 60000) begin
            errCount++;
            endSim();
        end
    end

    // ************************************************************
    // Compare and bus helpers
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
        i_pcrb_host.rd(idx, d0, d1, ok);
        chk({7'h0, ok}, 8'h01);
        chk(d0, exp);
        chk(d1, exp);
    endtask

    task automatic wrOne(input logic [7:0] idx, input logic [7:0] d);
        i_pcrb_host.wr(idx, {d}, ok);
        chk({7'h0, ok}, 8'h01);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic tIdent();
        rdChk(8'h00, {PART_ID, REV_LOW}); // part code read
        wrOne(8'h00, 8'hc0); // write attempt on code
        rdChk(8'h00, {PART_ID, REV_LOW}); // code unchanged
        rdChk(8'h01, OTP_VERSION); // version read
    endtask

    task automatic tReset();
        rdChk(8'h02, 8'h04); // discharge default set
        chk({7'h0, dischargeOn}, 8'h01); // discharge while off
    endtask

    task automatic tAutoInc();
        i_pcrb_host.wr(8'h14, {8'h0a, 8'h3c, 8'h03}, ok); // reserved bits left zero
        chk({7'h0, ok}, 8'h01); // every data byte acknowledged
        rdChk(8'h15, 8'h3c); // second byte lands one up
        rdChk(8'h16, 8'h03); // third byte lands two up
    endtask

    // Each entry: control byte, pin level, then on, discharge, pwm, multiphase.
    task automatic tBuck();
        logic [12:0] tbl [8];
        tbl = '{13'h0000, 13'h0084, 13'h00a8, 13'h00e4, 13'h00f8, 13'h01ba, 13'h03ab, 13'h0253};
        foreach (tbl[i]) begin
            @(negedge ref_clk);
            enPin = tbl[i][4];
            wrOne(8'h02, tbl[i][12:5]);
            chk({4'h0, buckOn, dischargeOn, forcePwm, forceMultiphase}, {4'h0, tbl[i][3:0]}); // decode
            rdChk(8'h02, tbl[i][12:5]); // control readback
        end
    endtask

    task automatic tStatus();
        @(negedge ref_clk);
        stat = 8'hff;
        rdChk(8'h1d, 8'h9c);
        rdChk(8'h26, 8'hff);
        rdChk(8'h1b, 8'h77);
        @(negedge ref_clk);
        stat = 8'h00;
        wrOne(8'h1b, 8'h77);
        rdChk(8'h1b, 8'h00);
    endtask

    task automatic tSoftRst();
        pulses = 0;
        wrOne(8'h18, 8'h01);
        rdChk(8'h18, 8'h00);
        chk(8'(pulses), 8'h01);
    endtask

    task automatic tRefuse();
        i_pcrb_host.probe(7'h61, ok);
        chk({7'h0, ok}, 8'h00);
        rdChk(8'h02, 8'h12); // bank untouched by foreign address
    endtask

    task automatic endSim();
        if (errCount == 0 && checkCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        tReset();
        tIdent();
        tAutoInc();
        tBuck();
        tStatus();
        tSoftRst();
        tRefuse();
        endSim();
    end
endmodule // tb

bind pcrb_regbank pcrb_regbank_sva i_pcrb_regbank_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .enPin(enPin), .buckOn(buckOn), .dischargeOn(dischargeOn), .forcePwm(forcePwm),
    .forceMultiphase(forceMultiphase), .softResetPulse(softResetPulse));

`default_nettype wire
